// ==== pkg/scscr_pkg.sv ====
/*
 * Shared constants and types for the serial configuration word of the clock synthesizer.
 * Assumes one 200 MHz system clock and an asynchronous active-high reset in every user.
 */
`default_nettype none

package scscr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Word geometry
    localparam int WORD_BITS = 47;
    localparam int SYNC_STAGES = 2;
    // Pin vector positions into the synchroniser
    localparam int PIN_STROBE = 0;
    localparam int PIN_REQUEST = 1;
    localparam int PIN_READ = 2;
    localparam int PIN_DATA = 3;
    localparam int PIN_LOAD_EN = 4;
    localparam int PIN_COUNT = 5;
    // Word index of serial bits 14..19 (mux select and postscaler)
    localparam int DEGLITCH_LO = 13;
    localparam int DEGLITCH_HI = 18;
    // Post-transfer freeze length in pixel periods
    localparam int FREEZE_PERIODS = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Field encodings
    localparam logic [1:0] FILTER_EXTERNAL = 2'h0;
    localparam logic [1:0] FILTER_500K = 2'h1;
    localparam logic [1:0] FILTER_1M5 = 2'h2;
    localparam logic [1:0] FILTER_5M = 2'h3;
    localparam logic [1:0] ROUTE_XTAL_HALF = 2'h0;
    localparam logic [1:0] ROUTE_POSTSCALER = 2'h1;
    localparam logic [1:0] ROUTE_PASSTHRU = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration word: last field is serial bit 1, the first bit shifted in
    typedef struct packed {
        logic [13:0] feedbackDiv;   // Serial bits 34..47
        logic [9:0] refDiv;         // Serial bits 24..33
        logic [3:0] loadDivM1;      // Serial bits 20..23
        logic [3:0] postDivM1;      // Serial bits 16..19
        logic [1:0] clockRoute;     // Serial bits 14..15
        logic vcoReset;             // Bit 13, clamps pump to analog ground
        logic extOscillatorPathOn;  // Bit 12
        logic vcoDisable;           // Bit 11
        logic pumpHighZ;            // Bit 10
        logic pumpInvert;           // Bit 9
        logic pumpLarge;            // Bit 8, 75 uA when set else 25 uA
        logic diffDisable;          // Bit 7
        logic pixelDisable;         // Bit 6
        logic loadDisable;          // Bit 5
        logic [1:0] filterSel;      // Bits 3..4
        logic refExternal;          // Bit 2
        logic largeSwing;           // Bit 1
    } scscr_config_type;

    localparam scscr_config_type CONFIG_RESET = '{
        feedbackDiv: 14'h0078,
        refDiv: 10'h014,
        loadDivM1: 4'h3,
        postDivM1: 4'h3,
        clockRoute: ROUTE_XTAL_HALF,
        vcoReset: 1'b1,
        extOscillatorPathOn: 1'b0,
        vcoDisable: 1'b0,
        pumpHighZ: 1'b0,
        pumpInvert: 1'b0,
        pumpLarge: 1'b0,
        diffDisable: 1'b0,
        pixelDisable: 1'b0,
        loadDisable: 1'b0,
        filterSel: FILTER_EXTERNAL,
        refExternal: 1'b0,
        largeSwing: 1'b0
    };

    typedef enum logic {PH_IDLE, PH_BIT} scscr_phase_type;

endpackage

`default_nettype wire

// ==== hdl/scscr_sync.sv ====
/*
 * Two-flop synchroniser for a group of asynchronous pin levels.
 * Assumes each pin holds steady for several clocks around any edge the logic cares about.
 */
`timescale 1ns/10ps
`default_nettype none

module scscr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,             // System clock
    input wire logic reset,             // Asynchronous, active high
    input wire logic [WIDTH-1:0] pins,  // Raw pin levels
    output logic [WIDTH-1:0] levels     // Synchronised levels
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    ////////////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second one, to contain metastability
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1_q <= RESET_VALUE;
            stage2_q <= RESET_VALUE;
        end else begin
            stage1_q <= pins;
            stage2_q <= stage1_q;
        end
    end

    assign levels = stage2_q;

endmodule

`default_nettype wire

// ==== hdl/scscr_top.sv ====
/*
 * Serial configuration path of the clock synthesizer: shift register, shadow register,
 * read-back, load clock divider with gating, and the pixel clock freeze after retuning.
 * Assumes the host keeps each strobe phase and the data pin steady for at least four
 * system clocks, and that pixelTick is a one-cycle pulse per pixel clock period.
 */
// What this block does
// R1 - Host sets request and direction before strobe falls, data at strobe rise.
// R2 - Write: host keeps request and direction low for all but the last bit.
// R3 - Last write bit with request high shifts in, then loads the shadow register.
// R4 - Read: host keeps request low, direction high, except optional first-bit refresh.
// R5 - Request on first read bit copies shadow into shift register; shadow unchanged.
// R6 - Read bits appear after strobe falls and advance on each strobe rise.
// R7 - Multi-bit fields travel least significant bit first.
// R8 - Bit 1 picks large or small differential swing; resets small.
// R9 - Bit 2 picks crystal or external reference; resets crystal.
// R10 - Bits 4..3 pick the loop filter; resets external filter.
// R11 - Bit 5 high forces load clock low and stops its counter.
// R12 - Load enable pin gates only the load clock output, synchronously.
// R13 - Bits 6 and 7 disable pixel and differential outputs; reset enabled.
// R14 - Bit 8 picks pump current, small after reset.
// R15 - Bit 9 inverts pump polarity; resets normal.
// R16 - Bit 10 floats the pump, bit 11 stops the oscillator; both reset enabled.
// R17 - Bit 12 enables the external oscillator path; resets off.
// R18 - Bit 13 clamps pump to ground; resets high, host clears it.
// R19 - Bits 15..14 route crystal half, postscaler or passthrough; reset crystal half.
// R20 - Postscaler and load moduli stored minus one; both reset to four.
// R21 - Reference divider bits 24..33 binary, resets to 20.
// R22 - Feedback divider bits 34..47 binary, resets to 120.
// R23 - Changing bits 14..19 freezes pixel outputs for several periods.
`timescale 1ns/10ps
`default_nettype none

module scscr_top #(
    parameter int FREEZE_LEN = scscr_pkg::FREEZE_PERIODS
) (
    input wire logic clock,                      // 200 MHz system clock
    input wire logic reset,                      // Asynchronous, active high
    input wire logic selectStrobe_n,             // Serial strobe pin, active low
    input wire logic transferRequest,            // Transfer request pin
    input wire logic readNotWrite,               // High reads, low writes
    input wire logic dataIn,                     // Data pin, input side
    output logic dataOut,                        // Data pin, output side
    output logic dataOe_n,                       // Data pin enable, low drives
    input wire logic loadClockEnable,            // Load clock gate pin
    input wire logic pixelTick,                  // One pulse per routed clock period
    output scscr_pkg::scscr_config_type configWord,  // Shadow register fields
    output logic loadClockOut,                   // Divided load clock
    output logic pixelFreeze                     // Pixel outputs held while high
);
    import scscr_pkg::*;

    localparam int FREEZE_BITS = $clog2(FREEZE_LEN + 1);
    localparam logic [FREEZE_BITS-1:0] FREEZE_LOAD = FREEZE_BITS'(FREEZE_LEN);

    logic [PIN_COUNT-1:0] pinLevels;
    logic strobeS_n;
    logic requestS;
    logic readS;
    logic dataS;
    logic loadEnableS;
    logic strobeDly_q;
    logic strobeFall;
    logic strobeRise;
    scscr_phase_type phase_q;
    logic readMode_q;
    logic request_q;
    logic [WORD_BITS-1:0] shift_q;
    logic [WORD_BITS-1:0] shiftIn;
    scscr_config_type shadow_q;
    logic dataOeN_q;
    logic writeTransfer;
    logic [3:0] loadCnt_q;
    logic loadToggle_q;
    logic loadGate_q;
    logic loadClock_q;
    logic loadRaw;
    logic [FREEZE_BITS-1:0] freezeCnt_q;
    logic freeze_q;
    logic routeChange;

    // Low count of a divide-by-(m1+1) waveform; odd moduli spend one more count low
    function automatic logic [4:0] lowCount(input logic [3:0] m1);
        logic [4:0] modulus;
        modulus = {1'b0, m1} + 5'h01;
        return modulus - {1'b0, modulus[4:1]};
    endfunction

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation; strobe and gate pins idle high
    scscr_sync #(
        .WIDTH(PIN_COUNT),
        .RESET_VALUE(5'h11)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .pins({loadClockEnable, dataIn, readNotWrite, transferRequest, selectStrobe_n}),
        .levels(pinLevels)
    );

    assign strobeS_n = pinLevels[PIN_STROBE];
    assign requestS = pinLevels[PIN_REQUEST];
    assign readS = pinLevels[PIN_READ];
    assign dataS = pinLevels[PIN_DATA];
    assign loadEnableS = pinLevels[PIN_LOAD_EN];

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe edge detection, on the synchronised level only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strobeDly_q <= 1'b1;
        end else begin
            strobeDly_q <= strobeS_n;
        end
    end

    assign strobeFall = strobeDly_q & ~strobeS_n;
    assign strobeRise = ~strobeDly_q & strobeS_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Bit cycle: direction and request are frozen at the falling edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_q <= PH_IDLE;
            readMode_q <= 1'b0;
            request_q <= 1'b0;
        end else if (strobeFall) begin
            phase_q <= PH_BIT;
            readMode_q <= readS;     // see R1
            request_q <= requestS;   // see R1
        end else if (strobeRise) begin
            phase_q <= PH_IDLE;
        end
    end

    // New bit enters at the top, so the first bit sent ends at index 0
    assign shiftIn = {dataS, shift_q[WORD_BITS-1:1]};  // see R7
    assign writeTransfer = strobeRise && phase_q == PH_BIT && !readMode_q && request_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Shift register; reads rotate so a full read can be repeated harmlessly
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shift_q <= CONFIG_RESET;
        end else if (strobeFall && readS && requestS) begin
            shift_q <= shadow_q;  // see R5
        end else if (strobeRise && phase_q == PH_BIT) begin
            if (readMode_q) begin
                shift_q <= {shift_q[0], shift_q[WORD_BITS-1:1]};  // see R6
            end else begin
                shift_q <= shiftIn;  // see R2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow register takes the whole word with the final bit, in one cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shadow_q <= CONFIG_RESET;  // see R8, R9, R10, R13, R14, R15, R16
        end else if (writeTransfer) begin
            shadow_q <= scscr_config_type'(shiftIn);  // see R3
        end
    end

    // Fields reach the analog side straight from the shadow flops
    assign configWord = shadow_q;  // see R17, R18, R19, R20, R21, R22

    ////////////////////////////////////////////////////////////////////////////////
    // Data pin drive: only in a read bit, released as soon as the strobe rises
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dataOeN_q <= 1'b1;
        end else if (strobeFall) begin
            dataOeN_q <= ~readS;  // see R4
        end else if (strobeRise) begin
            dataOeN_q <= 1'b1;
        end
    end

    assign dataOut = shift_q[0];  // see R6
    assign dataOe_n = dataOeN_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Load divider counts routed periods; disable bit stops it outright
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            loadCnt_q <= 4'h0;
            loadToggle_q <= 1'b0;
        end else if (shadow_q.loadDisable) begin
            loadCnt_q <= 4'h0;  // see R11
            loadToggle_q <= 1'b0;
        end else if (pixelTick) begin
            // Wraps at once when a smaller modulus arrives, no long run through 15
            loadCnt_q <= (loadCnt_q >= shadow_q.loadDivM1) ? 4'h0 : loadCnt_q + 4'h1;
            loadToggle_q <= ~loadToggle_q;
        end
    end

    // Divide by one follows the tick rate as a toggle
    assign loadRaw = (shadow_q.loadDivM1 == 4'h0) ? loadToggle_q :
        ({1'b0, loadCnt_q} >= lowCount(shadow_q.loadDivM1));

    ////////////////////////////////////////////////////////////////////////////////
    // Gate pin is sampled on every pixel tick, not only at load period ends, so a high phase can be cut short; counter keeps going
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            loadGate_q <= 1'b1;
        end else if (pixelTick) begin
            loadGate_q <= loadEnableS;  // see R12
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            loadClock_q <= 1'b0;
        end else begin
            loadClock_q <= loadRaw && loadGate_q && !shadow_q.loadDisable;  // see R11, R12
        end
    end

    assign loadClockOut = loadClock_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Retune freeze; other field changes leave the pixel outputs running
    assign routeChange = writeTransfer &&
        (shiftIn[DEGLITCH_HI:DEGLITCH_LO] != shadow_q[DEGLITCH_HI:DEGLITCH_LO]);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            freezeCnt_q <= '0;
            freeze_q <= 1'b0;
        end else if (routeChange) begin
            freezeCnt_q <= FREEZE_LOAD;  // see R23
            freeze_q <= 1'b1;
        end else if (pixelTick && freezeCnt_q != '0) begin
            freezeCnt_q <= freezeCnt_q - 1'b1;
            freeze_q <= (freezeCnt_q != FREEZE_BITS'(1));
        end
    end

    assign pixelFreeze = freeze_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence writeBitRise;
        strobeRise && phase_q == PH_BIT && !readMode_q;
    endsequence

    sequence readRefreshFall;
        strobeFall && readS && requestS;
    endsequence

    chk_write_shift: assert property (writeBitRise |=> // see R2
        shift_q == {$past(dataS), $past(shift_q[WORD_BITS-1:1])})
        else $error("write bit not shifted in at top");

    chk_write_transfer: assert property ((writeBitRise and request_q) |=> // see R3
        shadow_q == scscr_config_type'({$past(dataS), $past(shift_q[WORD_BITS-1:1])}))
        else $error("final write bit did not load shadow");

    chk_shadow_quiet: assert property ((phase_q == PH_BIT && readMode_q) |=> // see R5
        $stable(shadow_q))
        else $error("shadow changed during a read");

    chk_read_refresh: assert property (readRefreshFall |=> // see R5
        shift_q == $past(shadow_q) ##0 dataOut == $past(shadow_q.largeSwing))
        else $error("read refresh did not copy shadow");

    chk_read_drive: assert property (((strobeFall && readS) || // see R6
        (phase_q == PH_BIT && readMode_q && !strobeRise)) |=> !dataOe_n)
        else $error("data pin not driven in read bit");

    chk_read_rotate: assert property ((strobeRise && phase_q == PH_BIT && readMode_q) |=> // see R6
        dataOut == $past(shift_q[1]) ##1 dataOe_n)
        else $error("read did not advance or release");

    chk_reset_word: assert property ($fell(reset) |-> shadow_q == CONFIG_RESET && // see R21
        shadow_q.vcoReset && shadow_q.feedbackDiv == 14'h0078) // see R22, R18
        else $error("shadow reset value wrong");

    chk_load_disable: assert property (shadow_q.loadDisable |=> // see R11
        !loadClockOut && loadCnt_q == 4'h0)
        else $error("load clock not stopped");

    chk_load_gate: assert property ((!loadGate_q && !shadow_q.loadDisable) |=> // see R12
        !loadClockOut)
        else $error("load clock passed while gated");

    chk_freeze_start: assert property (routeChange |=> pixelFreeze [*2]) // see R23
        else $error("pixel freeze not raised on retune");

    chk_freeze_hold: assert property ((pixelFreeze && !pixelTick && !routeChange) |=> // see R23
        pixelFreeze)
        else $error("pixel freeze ended without a period");

endmodule

`default_nettype wire

// ==== bench/scscr_host_model.sv ====
/*
 * Host model driving the serial configuration pins of the clock synthesizer.
 * Assumes the bench resolves hostData and the device data output into pinLevel.
 */
`timescale 1ns/10ps
`default_nettype none

module scscr_host_model (
    input wire logic clock,        // Bench clock, falling edge used
    output logic selectStrobe_n,   // Strobe pin, active low
    output logic transferRequest,  // Transfer request pin
    output logic readNotWrite,     // High reads, low writes
    output logic hostData,         // Host side of the data pin
    input wire logic pinLevel      // Resolved data pin level
);
    import scscr_pkg::*;

    logic driving = 1'b0;

    initial begin
        selectStrobe_n = 1'b1;
        transferRequest = 1'b0;
        readNotWrite = 1'b0;
        hostData = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Released line toggles, so a stale level never passes for read data
    always @(negedge clock) begin
        if (!driving) begin
            hostData <= ~hostData;
        end
    end

    // One strobe cycle; phases of six clocks keep well above the sync limit
    task automatic bit_cycle(input logic req, input logic rnw, input logic d, output logic seen);
        @(negedge clock);
        transferRequest = req;
        readNotWrite = rnw;
        driving = !rnw;
        repeat (2) @(negedge clock);
        if (!rnw) begin
            hostData = d;
        end
        selectStrobe_n = 1'b0;
        repeat (6) @(negedge clock);
        seen = pinLevel;
        selectStrobe_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask

    // Serial bit 1 goes first, so each field travels low bit first
    task automatic write_word(input scscr_config_type w);
        logic s;
        for (int i = 0; i < WORD_BITS; i++) begin
            bit_cycle(i == WORD_BITS - 1, 1'b0, w[i], s);
        end
        driving = 1'b0;
    endtask

    task automatic read_word(input logic refresh, output scscr_config_type r);
        for (int i = 0; i < WORD_BITS; i++) begin
            bit_cycle(refresh && i == 0, 1'b1, 1'b0, r[i]);
        end
        transferRequest = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== bench/serial_clock_synth_control_register_tb.sv ====
/*
 * Self-checking bench for the serial configuration word: writes, read-back,
 * retune freeze and the load clock gates.
 * Assumes a 200 MHz clock and the host model driving the serial pins.
 */
`timescale 1ns/10ps
`default_nettype none

module serial_clock_synth_control_register_tb;
    import scscr_pkg::*;

    localparam int FREEZE_TEST = 2;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic selectStrobe_n, transferRequest, readNotWrite, hostData, dataOut, dataOe_n;
    logic loadClockEnable = 1'b1;
    logic pixelTick = 1'b0;
    logic loadClockOut, pixelFreeze, loadPrev;
    logic [1:0] tickDiv = 2'h0;
    wire logic dataPin;
    scscr_config_type shadowSeen, w, got;
    int nMismatch = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int freezeTicks = 0;
    int loadRises = 0;

    always #2.5 clock = ~clock;
    assign dataPin = (dataOe_n === 1'b0) ? dataOut : hostData;

    scscr_top #(.FREEZE_LEN(FREEZE_TEST)) dut_u (
        .clock(clock), .reset(reset), .selectStrobe_n(selectStrobe_n),
        .transferRequest(transferRequest), .readNotWrite(readNotWrite), .dataIn(dataPin),
        .dataOut(dataOut), .dataOe_n(dataOe_n), .loadClockEnable(loadClockEnable),
        .pixelTick(pixelTick), .configWord(shadowSeen), .loadClockOut(loadClockOut),
        .pixelFreeze(pixelFreeze)
    );

    scscr_host_model host_u (
        .clock(clock), .selectStrobe_n(selectStrobe_n), .transferRequest(transferRequest),
        .readNotWrite(readNotWrite), .hostData(hostData), .pinLevel(dataPin)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel tick every third clock, counts of frozen ticks and load rises
    always @(negedge clock) begin
        tickDiv <= (tickDiv == 2'h2) ? 2'h0 : tickDiv + 2'h1;
        pixelTick <= (tickDiv == 2'h2);
    end

    always @(posedge clock) begin
        loadPrev <= loadClockOut;
        if (pixelFreeze === 1'b1 && pixelTick === 1'b1) freezeTicks++;
        if (loadClockOut === 1'b1 && loadPrev === 1'b0) loadRises++;
        cycles++;
        if (cycles == 40000) begin
            nMismatch++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expected);
        samplesChecked++;
        if (seen !== expected) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Legal random word; zero or tiny dividers are undefined so stay out of them
    function automatic scscr_config_type rand_word();
        scscr_config_type r;
        r = scscr_config_type'(WORD_BITS'({$urandom, $urandom}));
        if (r.refDiv == 10'h000) r.refDiv = 10'h001;
        if (r.feedbackDiv < 14'h0002) r.feedbackDiv = 14'h0002;
        r.vcoReset = 1'b0;
        r.loadDisable = 1'b0;
        return r;
    endfunction

    task automatic apply(input scscr_config_type v);
        host_u.write_word(v);
        repeat (4) @(negedge clock);
        check("shadow", shadowSeen, v);
        host_u.read_word(1'b1, got);
        check("readback", got, v);
        check("shadow kept", shadowSeen, v);
    endtask

    // Window of twelve load periods; a tick comes every third clock
    task automatic load_window(input int m, input int expected);
        repeat (10) @(negedge clock);
        loadRises = 0;
        repeat (36 * m) @(negedge clock);
        check("load rises", (loadRises >= expected - 1 && loadRises <= expected), 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(38));
        repeat (3) @(posedge clock);
        @(negedge clock) reset = 1'b0;
        repeat (2) @(negedge clock);
        check("reset shadow", shadowSeen, CONFIG_RESET);
        host_u.read_word(1'b0, got);
        check("plain read", got, CONFIG_RESET);
        host_u.read_word(1'b1, got);
        check("refresh read", got, CONFIG_RESET);
        // Every filter and route code, then random and boundary words
        for (int i = 0; i < 4; i++) begin
            w = rand_word();
            w.filterSel = i[1:0];
            w.clockRoute = i[1:0];
            apply(w);
        end
        repeat (4) apply(rand_word());
        w = '1;
        w.loadDisable = 1'b0;
        apply(w);
        w = '0;
        w.feedbackDiv = 14'h0002;
        w.refDiv = 10'h001;
        apply(w);
        // Postscaler change freezes, a bit 1 change does not
        freezeTicks = 0;
        w.postDivM1 = 4'h5;
        host_u.write_word(w);
        repeat (8) @(negedge clock);
        for (int k = 0; k < 100 && pixelFreeze === 1'b1; k++) @(negedge clock);
        check("freeze ticks", freezeTicks, FREEZE_TEST);
        freezeTicks = 0;
        w.largeSwing = 1'b1;
        host_u.write_word(w);
        repeat (20) @(negedge clock);
        check("no freeze", freezeTicks, 0);
        // Load divider moduli four and three
        for (int m = 4; m > 2; m--) begin
            w.loadDivM1 = 4'(m - 1);
            host_u.write_word(w);
            load_window(m, 12);
        end
        loadClockEnable = 1'b0;
        load_window(3, 0);
        check("gated low", loadClockOut, 1'b0);
        loadClockEnable = 1'b1;
        load_window(3, 12);
        w.loadDisable = 1'b1;
        host_u.write_word(w);
        load_window(3, 0);
        check("disabled low", loadClockOut, 1'b0);
        report_and_stop();
    end
endmodule

`default_nettype wire
